// *** verilog/gbp_top.sv ***
// A/B pin ports with data and direction registers behind an AXI4-Lite slave.
// Assumes external bus sequencing outside; echoed read data answers in the same cycle.
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "gbp_defs.svh"

// Overview of operation
// (R1) A set direction bit drives its pin, a clear bit leaves it a high-impedance input.
// (R2) A data register read returns the pin level for input bits and the latch for output bits.
// (R3) Both direction registers clear to zero on reset.
// (R4) With the external bus active, port A carries address 15..8 and the upper data byte; in the narrow modes its data is the lower byte.
// (R5) With the external bus active, port B carries address 7..0 and the lower data byte; in the narrow modes it carries address only.
// (R6) In single-chip operation the pins are plain I/O under data and direction registers.
// (R7) Wide, visible emulation narrow and peripheral modes multiplex address and data on both ports.
// (R8) In expanded and peripheral modes the four registers leave the map and accesses go outside.
// (R9) While mapped, the registers may be read and written at any time.
// (R10) Software waits a cycle after a direction write before reading the matching data register.
// (R11) Port A data, port B data, port A and port B direction sit at indices 0 to 3.
// (R12) Expanded narrow mode multiplexes address and data on port A, port B carries address only.
module gbp_top
  import gbp_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // AXI4-Lite write
  input wire logic [`GBP_AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [`GBP_AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // External bus sequencer
  input wire gbp_xbus_t xbus,
  output logic [15:0] bus_data_in,
  output gbp_echo_t echo,
  input wire logic [7:0] echo_rdata,
  // Pins
  input wire logic [7:0] pin_a_in,
  output logic [7:0] pin_a_out,
  output logic [7:0] pin_a_oe,
  input wire logic [7:0] pin_b_in,
  output logic [7:0] pin_b_out,
  output logic [7:0] pin_b_oe
);

  gbp_mode_t mode_q;
  logic internal_visibility_q;
  logic [7:0] data_q [2], dir_q [2], pin_in [2], bus_val [2], bus_oe [2], pin_out_w [2], pin_oe_w [2];
  logic aw_full_q, w_full_q;
  logic [`GBP_AXI_AW-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic do_write, do_read, bus_active, mux_wide, wr_port, rd_port;
  logic [`GBP_IDX_W-1:0] wr_idx, rd_idx;
  logic [31:0] rd_val;
  logic [1:0] rd_resp, wr_resp;

  assign pin_in[0] = pin_a_in;
  assign pin_in[1] = pin_b_in;
  assign wr_idx = awaddr_q[`GBP_IDX_LSB +: `GBP_IDX_W];
  assign rd_idx = s_axi_araddr[`GBP_IDX_LSB +: `GBP_IDX_W];
  assign wr_port = wr_idx <= `GBP_IDX_DIR_B;
  assign rd_port = rd_idx <= `GBP_IDX_DIR_B;
  assign do_write = aw_full_q && w_full_q && !s_axi_bvalid;
  assign do_read = s_axi_arvalid && s_axi_arready;
  assign bus_active = mode_q != gbp_mode_single_chip;
  // (R7) modes with full 16-bit multiplexing
  assign mux_wide = (mode_q == gbp_mode_exp_wide) || (mode_q == gbp_mode_peripheral)
    || ((mode_q == gbp_mode_emul_narrow) && internal_visibility_q);

  // Write address and data are taken independently, in either order
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      aw_full_q <= 1'b0;
      awaddr_q <= '0;
      s_axi_awready <= 1'b0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_full_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end
    else if (do_write)
      aw_full_q <= 1'b0;
    else if (!aw_full_q && !s_axi_bvalid)
      s_axi_awready <= 1'b1;
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      w_full_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
      s_axi_wready <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_full_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end
    else if (do_write)
      w_full_q <= 1'b0;
    else if (!w_full_q && !s_axi_bvalid)
      s_axi_wready <= 1'b1;
  end

  assign wr_resp = (wr_port || (wr_idx >= `GBP_IDX_RSV_LO && wr_idx <= `GBP_IDX_RSV_HI) || wr_idx == `GBP_IDX_MODE)
    ? `GBP_RESP_OKAY : `GBP_RESP_SLVERR;

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `GBP_RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_resp;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Read decode; unmapped indices answer with an error and zero data
  always_comb
  begin
    rd_val = '0;
    rd_resp = `GBP_RESP_OKAY;
    if (rd_port && bus_active)
      // (R8) answered from outside
      rd_val = {24'h000000, echo_rdata};
    else if (rd_idx == `GBP_IDX_DATA_A || rd_idx == `GBP_IDX_DATA_B)
      // (R2) pin level or latch
      rd_val = {24'h000000, (dir_q[rd_idx[0]] & data_q[rd_idx[0]]) | (~dir_q[rd_idx[0]] & pin_in[rd_idx[0]])};
    else if (rd_idx == `GBP_IDX_DIR_A || rd_idx == `GBP_IDX_DIR_B)
      rd_val = {24'h000000, dir_q[rd_idx[0]]};
    else if (rd_idx >= `GBP_IDX_RSV_LO && rd_idx <= `GBP_IDX_RSV_HI)
      rd_val = '0;
    else if (rd_idx == `GBP_IDX_MODE)
      rd_val = {28'h0000000, internal_visibility_q, mode_q};
    else
      rd_resp = `GBP_RESP_SLVERR;
  end

  // (R9) reads taken whenever no read response is outstanding
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `GBP_RESP_OKAY;
    end
    else if (do_read)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_resp;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
    else if (!s_axi_rvalid)
      s_axi_arready <= 1'b1;
  end

  // Mode select; unknown codes are dropped so the enum never holds an illegal value
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mode_q <= gbp_mode_single_chip;
      internal_visibility_q <= `GBP_VIS_RESET;
    end
    else if (do_write && wstrb_q[0] && wr_idx == `GBP_IDX_MODE)
    begin
      if (wdata_q[`GBP_MODE_FIELD_HI:0] <= `GBP_MODE_MAX)
        mode_q <= gbp_mode_t'(wdata_q[`GBP_MODE_FIELD_HI:0]);
      internal_visibility_q <= wdata_q[`GBP_MODE_VIS_BIT];
    end
  end

  // (R8) echo strobes toward the external bus
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      echo <= '0;
    else
    begin
      echo.wr_stb <= do_write && wr_port && bus_active && wstrb_q[0];
      echo.rd_stb <= do_read && rd_port && bus_active;
      echo.wr_index <= wr_idx[1:0];
      echo.rd_index <= rd_idx[1:0];
      echo.wdata <= wdata_q[7:0];
    end
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      bus_data_in <= '0;
    else
      bus_data_in <= {pin_a_in, pin_b_in};
  end

  // External bus drive per port
  always_comb
  begin
    if (xbus.addr_phase)
    begin
      // (R4) upper address on port A
      bus_val[0] = xbus.addr[15:8];
      // (R5) lower address on port B
      bus_val[1] = xbus.addr[7:0];
      bus_oe[0] = {8{mode_q != gbp_mode_peripheral}};
      bus_oe[1] = {8{mode_q != gbp_mode_peripheral}};
    end
    else if (mux_wide)
    begin
      // (R7) both data bytes
      bus_val[0] = xbus.dout[15:8];
      bus_val[1] = xbus.dout[7:0];
      bus_oe[0] = {8{xbus.doe}};
      bus_oe[1] = {8{xbus.doe}};
    end
    else
    begin
      // (R12) narrow data on port A, address held on port B
      bus_val[0] = xbus.dout[7:0];
      bus_val[1] = xbus.addr[7:0];
      bus_oe[0] = {8{xbus.doe}};
      bus_oe[1] = 8'hFF;
    end
  end

  genvar p;
  generate
    for (p = 0; p < 2; p++)
    begin : g_port
      // (R11) data and direction writes by index
      always_ff @(posedge clock or posedge sys_rst)
      begin
        if (sys_rst)
        begin
          data_q[p] <= `GBP_DATA_RESET;
          // (R3) direction clears on reset
          dir_q[p] <= `GBP_DIR_RESET;
        end
        else if (do_write && wstrb_q[0] && !bus_active)
        begin
          if (wr_idx == `GBP_IDX_W'(`GBP_IDX_DATA_A + p))
            data_q[p] <= wdata_q[7:0];
          if (wr_idx == `GBP_IDX_W'(`GBP_IDX_DIR_A + p))
            dir_q[p] <= wdata_q[7:0];
        end
      end

      gbp_pin_slice u_slice
      (
        .clock(clock),
        .sys_rst(sys_rst),
        .gpio_data(data_q[p]),
        .gpio_dir(dir_q[p]),
        .bus_active(bus_active),
        .bus_val(bus_val[p]),
        .bus_oe(bus_oe[p]),
        .pin_out_q(pin_out_w[p]),
        .pin_oe_q(pin_oe_w[p])
      );
    end
  endgenerate

  assign pin_a_out = pin_out_w[0];
  assign pin_a_oe = pin_oe_w[0];
  assign pin_b_out = pin_out_w[1];
  assign pin_b_oe = pin_oe_w[1];

  // First edge after release still sees reset in the past
  a_dir_reset_zero: assert property (@(posedge clock) disable iff (sys_rst) // (R3)
    $past(sys_rst) |-> (dir_q[0] == 8'h00 && dir_q[1] == 8'h00))
    else $error("direction registers not cleared by reset");
  a_read_pin_mux: assert property (@(posedge clock) disable iff (sys_rst) // (R2)
    (do_read && !bus_active && rd_idx == `GBP_IDX_DATA_A)
    |=> s_axi_rvalid
    && s_axi_rdata[7:0] == (($past(dir_q[0]) & $past(data_q[0])) | (~$past(dir_q[0]) & $past(pin_a_in))))
    else $error("port A read does not mix pins and latch");
  a_port_a_addr: assert property (@(posedge clock) disable iff (sys_rst) // (R4)
    (bus_active && xbus.addr_phase) |=> pin_a_out == $past(xbus.addr[15:8]))
    else $error("port A not carrying upper address");
  a_port_b_addr: assert property (@(posedge clock) disable iff (sys_rst) // (R5)
    (bus_active && xbus.addr_phase) |=> pin_b_out == $past(xbus.addr[7:0]))
    else $error("port B not carrying lower address");
  a_wide_data_hi: assert property (@(posedge clock) disable iff (sys_rst) // (R7)
    (mode_q == gbp_mode_exp_wide && !xbus.addr_phase)
    |=> pin_a_out == $past(xbus.dout[15:8]) && pin_a_oe == {8{$past(xbus.doe)}})
    else $error("wide mode port A not carrying upper data");
  a_echo_no_store: assert property (@(posedge clock) disable iff (sys_rst) // (R8)
    (do_write && wr_port && bus_active && wstrb_q[0])
    |=> echo.wr_stb && $stable(data_q[0]) && $stable(dir_q[1]) ##1 !echo.wr_stb)
    else $error("external access stored locally or echo not a pulse");
  a_data_write_any: assert property (@(posedge clock) disable iff (sys_rst) // (R9)
    (do_write && wstrb_q[0] && !bus_active && wr_idx == `GBP_IDX_DATA_A)
    |=> data_q[0] == $past(wdata_q[7:0]) ##[0:2] s_axi_bvalid)
    else $error("port A data write not taken");
  a_dir_b_index: assert property (@(posedge clock) disable iff (sys_rst) // (R11)
    (do_write && wstrb_q[0] && !bus_active && wr_idx == `GBP_IDX_DIR_B)
    |=> dir_q[1] == $past(wdata_q[7:0]) && $stable(dir_q[0]))
    else $error("port B direction not at its index");
  a_narrow_b_addr: assert property (@(posedge clock) disable iff (sys_rst) // (R12)
    (mode_q == gbp_mode_exp_narrow && !xbus.addr_phase)
    |=> pin_b_out == $past(xbus.addr[7:0]) && pin_b_oe == 8'hFF)
    else $error("narrow mode port B not holding address");

endmodule

// *** verilog/gbp_defs.svh ***
// Offsets, field positions and reset values of the A/B pin ports.
// Assumes a 32-bit AXI4-Lite bus; register index times four is the byte address.
`ifndef GBP_DEFS_SVH
`define GBP_DEFS_SVH

`define GBP_AXI_AW 8
`define GBP_IDX_LSB 2
`define GBP_IDX_W 6

`define GBP_IDX_DATA_A 6'h00
`define GBP_IDX_DATA_B 6'h01
`define GBP_IDX_DIR_A 6'h02
`define GBP_IDX_DIR_B 6'h03
`define GBP_IDX_RSV_LO 6'h04
`define GBP_IDX_RSV_HI 6'h07
`define GBP_IDX_MODE 6'h10

`define GBP_MODE_FIELD_HI 2
`define GBP_MODE_VIS_BIT 3
`define GBP_MODE_MAX 3'h4

`define GBP_DATA_RESET 8'h00
`define GBP_DIR_RESET 8'h00
`define GBP_VIS_RESET 1'h0

`define GBP_RESP_OKAY 2'h0
`define GBP_RESP_SLVERR 2'h2

`endif

// *** verilog/gbp_pkg.sv ***
// Types shared by the A/B pin port block.
// Assumes the constants header is included by the modules that use it.
package gbp_pkg;

  typedef enum logic [2:0]
  {
    gbp_mode_single_chip,
    gbp_mode_exp_narrow,
    gbp_mode_exp_wide,
    gbp_mode_emul_narrow,
    gbp_mode_peripheral
  } gbp_mode_t;

  // External bus timing side, driven by the bus sequencer outside this block
  typedef struct packed
  {
    logic [15:0] addr;
    logic [15:0] dout;
    logic doe;
    logic addr_phase;
  } gbp_xbus_t;

  // Register accesses passed out to the external bus
  typedef struct packed
  {
    logic wr_stb;
    logic rd_stb;
    logic [1:0] wr_index;
    logic [1:0] rd_index;
    logic [7:0] wdata;
  } gbp_echo_t;

endpackage

// *** verilog/gbp_pin_slice.sv ***
// One 8-bit pin port: picks general-purpose or external bus drive.
// Assumes pin inputs synchronous to clock; outputs are registered.
`timescale 1ns/1ps
`include "gbp_defs.svh"

module gbp_pin_slice
  import gbp_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // General-purpose side
  input wire logic [7:0] gpio_data,
  input wire logic [7:0] gpio_dir,
  // External bus side
  input wire logic bus_active,
  input wire logic [7:0] bus_val,
  input wire logic [7:0] bus_oe,
  // Pin drive
  output logic [7:0] pin_out_q,
  output logic [7:0] pin_oe_q
);

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pin_out_q <= `GBP_DATA_RESET;
      pin_oe_q <= `GBP_DIR_RESET;
    end
    else if (bus_active)
    begin
      pin_out_q <= bus_val;
      pin_oe_q <= bus_oe;
    end
    else
    begin
      // (R6) latch drives pin
      pin_out_q <= gpio_data;
      // (R1) direction sets enable
      pin_oe_q <= gpio_dir;
    end
  end

  a_gpio_dir_oe: assert property (@(posedge clock) disable iff (sys_rst) // (R1)
    !bus_active |=> pin_oe_q == $past(gpio_dir))
    else $error("pin enable does not follow direction register");

  a_gpio_out_data: assert property (@(posedge clock) disable iff (sys_rst) // (R6)
    !bus_active |=> pin_out_q == $past(gpio_data))
    else $error("pin output does not follow data latch");

endmodule

// *** tb/gbp_ext_model.sv ***
// Far side of the A/B pins: outside drivers and an echo target.
// Assumes the bench sets the outside levels; pins are resolved here.
`timescale 1ns/1ps

module gbp_ext_model
  import gbp_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Pin drive from the block and from outside
  input wire logic [7:0] pin_a_out,
  input wire logic [7:0] pin_a_oe,
  input wire logic [7:0] pin_b_out,
  input wire logic [7:0] pin_b_oe,
  input wire logic [7:0] ext_a,
  input wire logic [7:0] ext_b,
  output logic [7:0] pin_a_in,
  output logic [7:0] pin_b_in,
  // Echoed accesses
  input wire gbp_echo_t echo,
  output logic [7:0] echo_rdata,
  output logic [9:0] last_wr_q
);
  // Enabled bits follow the block, the rest the outside level
  assign pin_a_in = (pin_a_oe & pin_a_out) | (~pin_a_oe & ext_a);
  assign pin_b_in = (pin_b_oe & pin_b_out) | (~pin_b_oe & ext_b);
  // Outside target keeps the last echoed write; reads return its byte
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      last_wr_q <= 10'h000;
    else if (echo.wr_stb)
      last_wr_q <= {echo.wr_index, echo.wdata};
  end
  assign echo_rdata = last_wr_q[7:0];
endmodule

// *** tb/test_bus_port_ab_direction_regs.sv ***
// Self-checking bench for the A/B pin ports behind AXI4-Lite.
// Assumes the outside model resolves pins and answers echoed reads.
`timescale 1ns/1ps

module test_bus_port_ab_direction_regs
  import gbp_pkg::*;
;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, ext_a = 8'h00, ext_b = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  logic [7:0] pa_in, pa_out, pa_oe, pb_in, pb_out, pb_oe, erd;
  logic [9:0] last_wr;
  logic [15:0] bus_in;
  gbp_xbus_t xbus = '0;
  gbp_echo_t echo;
  int n_mismatch = 0;
  int cmp_count = 0;

  always #25 clock = ~clock;

  gbp_top u_gbp_top (.clock(clock), .sys_rst(sys_rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .xbus(xbus), .bus_data_in(bus_in),
    .echo(echo), .echo_rdata(erd), .pin_a_in(pa_in), .pin_a_out(pa_out), .pin_a_oe(pa_oe),
    .pin_b_in(pb_in), .pin_b_out(pb_out), .pin_b_oe(pb_oe));

  gbp_ext_model u_gbp_ext_model (.clock(clock), .sys_rst(sys_rst), .pin_a_out(pa_out), .pin_a_oe(pa_oe),
    .pin_b_out(pb_out), .pin_b_oe(pb_oe), .ext_a(ext_a), .ext_b(ext_b), .pin_a_in(pa_in),
    .pin_b_in(pb_in), .echo(echo), .echo_rdata(erd), .last_wr_q(last_wr));

  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  // Address and data offered together, each released once taken
  // Waits without limit; only the watchdog ends a hung transfer
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge clock);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd))
    begin
      @(posedge clock);
      if (awready && !ad)
      begin
        awvalid <= 1'b0;
        ad = 1'b1;
      end
      if (wready && !wd)
      begin
        wvalid <= 1'b0;
        wd = 1'b1;
      end
    end
    do
      @(posedge clock);
    while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
      @(posedge clock);
    while (!arready);
    arvalid <= 1'b0;
    do
      @(posedge clock);
    while (!rvalid);
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  // Reset: directions clear, no pin driven, data reads show the outside levels
  task automatic t_reset();
    sys_rst <= 1'b1;
    cyc(8);
    sys_rst <= 1'b0;
    rd(8'h08, d, r);
    chk({r, d}, 34'h0);
    rd(8'h0C, d, r);
    chk({r, d}, 34'h0);
    rd(8'h00, d, r);
    chk({r, d}, {26'h0, ext_a});
    rd(8'h04, d, r);
    chk({r, d}, {26'h0, ext_b});
    chk({2'h0, pa_oe, pa_out, pb_oe, pb_out}, 34'h0);
  endtask

  // Single chip: direction selects drive and read-back source per bit
  task automatic t_gpio();
    ext_a <= 8'h3C;
    ext_b <= 8'hC3;
    wr(8'h08, 32'hF0, r);
    wr(8'h00, 32'hA5, r);
    wr(8'h0C, 32'h0F, r);
    wr(8'h04, 32'h3C, r);
    // two idle cycles after the last write
    cyc(2);
    chk({2'h0, pa_oe, pa_out, pb_oe, pb_out}, 34'hF0A50F3C);
    chk({18'h0, bus_in}, 34'hACCC);
    rd(8'h00, d, r);
    chk({r, d}, 34'hAC);
    rd(8'h04, d, r);
    chk({r, d}, 34'hCC);
    rd(8'h08, d, r);
    chk({r, d}, 34'hF0);
    rd(8'h0C, d, r);
    chk({r, d}, 34'h0F);
    wstrb <= 4'hE;
    wr(8'h00, 32'hFF, r);
    wstrb <= 4'hF;
    rd(8'h00, d, r);
    chk({r, d}, 34'hAC);
    wr(8'h14, 32'hFF, r);
    chk({32'h0, r}, 34'h0);
    rd(8'h10, d, r);
    chk({r, d}, 34'h0);
    wr(8'h80, 32'hFF, r);
    chk({32'h0, r}, 34'h2);
    rd(8'h80, d, r);
    chk({r, d}, {2'h2, 32'h0});
  endtask

  // Bus modes: pin content per phase, then echoed accesses
  task automatic t_modes();
    logic [3:0] md [8] = '{4'h2, 4'h2, 4'h1, 4'h1, 4'h3, 4'hB, 4'h4, 4'h4};
    logic ph [8] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
    logic [31:0] ex [8] = '{32'hFFABFFCD, 32'hFF12FF34, 32'hFFCDFF34, 32'hFF12FF34, 32'hFFCDFF34,
      32'hFFABFFCD, 32'hFFABFFCD, 32'h00120034};
    for (int i = 0; i < 8; i++)
    begin
      wr(8'h40, {28'h0, md[i]}, r);
      xbus <= '{addr: 16'h1234, dout: 16'hABCD, doe: 1'b1, addr_phase: ph[i]};
      cyc(3);
      chk({2'h0, pa_oe, pa_out, pb_oe, pb_out}, {2'h0, ex[i]});
    end
    // Codes above peripheral are dropped and the mode stays
    wr(8'h40, 32'h5, r);
    rd(8'h40, d, r);
    chk({r, d}, 34'h4);
    wr(8'h04, 32'h5A, r);
    // write goes outside; the model stores the strobe one edge later
    cyc(1);
    chk({22'h0, r, last_wr}, {24'h0, 10'h15A});
    rd(8'h00, d, r);
    chk({r, d}, 34'h5A);
    chk({31'h0, echo.rd_stb, echo.rd_index}, 34'h4);
    wr(8'h40, 32'h0, r);
    rd(8'h04, d, r);
    chk({r, d}, 34'hCC);
  endtask

  initial
  begin
    t_reset();
    t_gpio();
    t_modes();
    t_reset();
    test_done();
  end

  // Watchdog: whole run needs well under 2000 cycles
  initial
  begin
    #(50 * 5000);
    n_mismatch++;
    test_done();
  end
endmodule
